// ---- pch_config_regs.sv ----
// configuration header register bank from class code to power cap header
// ---------------------------------------------------------------------
// ---------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none

module pch_config_regs (
   // clock, reset, enable
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire logic        core_ce,
   // configuration access port
   input  wire logic        cfg_write,
   input  wire logic        cfg_read,
   input  wire logic [5:0]  cfg_dword,
   input  wire logic [3:0]  cfg_byte_en,
   input  wire logic [31:0] cfg_wdata,
   output logic      [31:0] cfg_rdata,
   output logic             cfg_rvalid,
   // serial memory preset load
   input  wire logic        ee_load,
   input  wire logic [15:0] ee_subsys_vend,
   input  wire logic [15:0] ee_subsys,
   input  wire logic [7:0]  ee_burst_need,
   input  wire logic [7:0]  ee_access_need,
   // quadlet data path
   input  wire logic        quad_in_valid,
   input  wire logic        quad_in_exempt,
   input  wire logic [31:0] quad_in,
   output logic      [31:0] quad_out,
   output logic             quad_out_valid,
   // settings to the rest of the controller
   output logic      [7:0]  cache_line_words,
   output logic      [7:0]  bus_hold_clocks,
   output logic      [19:0] op_base_page,
   output logic      [7:0]  irq_route_line,
   output logic             swap_enable
);

   // ---------------------------------------------------------------
   // state and next state
   // ---------------------------------------------------------------
   pch_pkg::pch_state_t st;       // registered state
   pch_pkg::pch_state_t next_st;  // next state

   // ---------------------------------------------------------------
   // dword index of each register
   // ---------------------------------------------------------------
   // only offset bits 7..2 reach the bank, as a dword index
   localparam logic [5:0] DW_CLASS = pch_pkg::OFF_CLASS_CODE[7:2];
   localparam logic [5:0] DW_MISC  = pch_pkg::OFF_CACHE_LINE[7:2];
   localparam logic [5:0] DW_BASE  = pch_pkg::OFF_OP_BASE[7:2];
   localparam logic [5:0] DW_SUBS  = pch_pkg::OFF_SUBSYS_VEND[7:2];
   localparam logic [5:0] DW_CAPP  = pch_pkg::OFF_CAP_PTR[7:2];
   localparam logic [5:0] DW_IRQ   = pch_pkg::OFF_IRQ_LINE[7:2];
   localparam logic [5:0] DW_CTRL  = pch_pkg::OFF_HOST_CTRL[7:2];
   localparam logic [5:0] DW_PCAP  = pch_pkg::OFF_POWER_CAP[7:2];

   // ---------------------------------------------------------------
   // helper terms
   // ---------------------------------------------------------------
   logic [31:0] read_word;   // addressed dword as read
   logic [7:0]  cl_wr;       // byte written to cache line
   logic        cl_legal;    // written size is a legal power
   logic        wr_misc;     // write to cache/timer dword
   logic        wr_base;     // write to base dword
   logic        wr_irq;      // write to interrupt dword
   logic        wr_ctrl;     // write to control dword
   logic [31:0] swapped;     // byte reversed input quadlet

   // ---------------------------------------------------------------
   // read view of the header
   // ---------------------------------------------------------------
   // unmapped dwords and out-of-scope bytes read zero
   // the revision lane of dword 2 is another block's; it reads zero
   always_comb begin
      read_word = 32'h00000000;
      case (cfg_dword)
         DW_CLASS: begin
            read_word = {pch_pkg::CLASS_BASE,
                         pch_pkg::CLASS_SUB,
                         pch_pkg::CLASS_PROG_IF,
                         8'h00};
         end
         DW_MISC: begin
            read_word = {pch_pkg::SELF_TEST_VAL,
                         pch_pkg::HEADER_TYPE_VAL,
                         st.bus_hold,
                         st.cache_line};
         end
         DW_BASE: begin
            read_word = {st.op_base, pch_pkg::OP_BASE_LOW};
         end
         DW_SUBS: begin
            read_word = {st.subsys, st.subsys_vend};
         end
         DW_CAPP: begin
            read_word = {24'h000000, pch_pkg::CAP_PTR_VAL};
         end
         DW_IRQ: begin
            read_word = {st.access_need,
                         st.burst_need,
                         pch_pkg::IRQ_PIN_VAL,
                         st.irq_line};
         end
         DW_CTRL: begin
            read_word = {31'h00000000, st.swap};
         end
         DW_PCAP: begin
            read_word = {16'h0000,
                         pch_pkg::CAP_NEXT_VAL,
                         pch_pkg::CAPABILITY_IDENTIFIER_VAL};
         end
         default: begin
            read_word = 32'h00000000;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // write decode and cache line legalisation
   // ---------------------------------------------------------------
   // only the writable dwords are decoded; any other write is
   // taken and dropped, so the bus sees a normal completion
   always_comb begin
      wr_misc  = cfg_write && (cfg_dword == DW_MISC);
      wr_base  = cfg_write && (cfg_dword == DW_BASE);
      wr_irq   = cfg_write && (cfg_dword == DW_IRQ);
      wr_ctrl  = cfg_write && (cfg_dword == DW_CTRL);
      cl_wr    = cfg_wdata[7:0];
      // one bit set, inside 2..128
      cl_legal = (cl_wr >= pch_pkg::CACHE_LINE_MIN)
              && (cl_wr <= pch_pkg::CACHE_LINE_MAX)
              && ((cl_wr & (cl_wr - 8'h01)) == 8'h00);
   end

   // ---------------------------------------------------------------
   // byte reversal of the data path quadlet
   // ---------------------------------------------------------------
   always_comb begin
      swapped = 32'h00000000;
      for (int b = 0; b < 4; b++) begin
         swapped[8*b +: 8] = quad_in[8*(3-b) +: 8];
      end
   end

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      next_st = st;
      // read answer, one cycle after the request
      // read_word comes from st, so a same-cycle write is not seen
      next_st.rvalid = cfg_read;
      if (cfg_read) begin
         next_st.rdata = read_word;
      end

      // cache line and bus hold timer
      if (wr_misc && cfg_byte_en[0]) begin
         next_st.cache_line = cl_legal ? cl_wr : 8'h00;
      end
      if (wr_misc && cfg_byte_en[1]) begin
         next_st.bus_hold = cfg_wdata[15:8];
      end

      // base: bytes 1..3 hold writable bits, low 12 stay zero
      if (wr_base && cfg_byte_en[1]) begin
         next_st.op_base[3:0] = cfg_wdata[15:12];
      end
      if (wr_base && cfg_byte_en[2]) begin
         next_st.op_base[11:4] = cfg_wdata[23:16];
      end
      if (wr_base && cfg_byte_en[3]) begin
         next_st.op_base[19:12] = cfg_wdata[31:24];
      end

      // interrupt line only; pin and loaded bytes ignore writes
      if (wr_irq && cfg_byte_en[0]) begin
         next_st.irq_line = cfg_wdata[7:0];
      end

      // swap bit; upper bits are not stored
      // hence the reserved bits can never read back as one
      if (wr_ctrl && cfg_byte_en[0]) begin
         next_st.swap = cfg_wdata[pch_pkg::SWAP_BIT];
      end

      // preset load from the serial memory loader; no write path
      // from the config port exists for these fields
      if (ee_load) begin
         next_st.subsys_vend = ee_subsys_vend;
         next_st.subsys      = ee_subsys;
         next_st.burst_need  = ee_burst_need;
         next_st.access_need = ee_access_need;
      end

      // data path: exempt quadlets pass straight
      // the exempt flag comes from the address decode upstream
      next_st.quad_valid = quad_in_valid;
      if (quad_in_valid) begin
         next_st.quad_out = (st.swap && !quad_in_exempt) ? swapped
                                                         : quad_in;
      end
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   // clock enable low freezes every field
   // limitation: a load strobe that comes while ce is low is lost
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         st.cache_line  <= pch_pkg::RST_CACHE_LINE;
         st.bus_hold    <= pch_pkg::RST_BUS_HOLD;
         st.op_base     <= pch_pkg::RST_OP_BASE;
         st.subsys_vend <= pch_pkg::RST_SUBSYS_VEND;
         st.subsys      <= pch_pkg::RST_SUBSYS;
         st.irq_line    <= pch_pkg::RST_IRQ_LINE;
         st.burst_need  <= pch_pkg::RST_BURST_NEED;
         st.access_need <= pch_pkg::RST_ACCESS_NEED;
         st.swap        <= pch_pkg::RST_SWAP;
         st.rdata       <= 32'h00000000;
         st.rvalid      <= 1'b0;
         st.quad_out    <= 32'h00000000;
         st.quad_valid  <= 1'b0;
      end else if (core_ce) begin
         st <= next_st;
      end
   end

   // ---------------------------------------------------------------
   // outputs, each straight from a state field
   // ---------------------------------------------------------------
   assign cfg_rdata        = st.rdata;
   assign cfg_rvalid       = st.rvalid;
   assign quad_out         = st.quad_out;
   assign quad_out_valid   = st.quad_valid;
   assign cache_line_words = st.cache_line;
   assign bus_hold_clocks  = st.bus_hold;
   assign op_base_page     = st.op_base;   // firmware sets it at power up
   assign irq_route_line   = st.irq_line;
   assign swap_enable      = st.swap;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking chk_cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);

   cache_line_legal_a: assert property (
      (cache_line_words == 8'h00) || (cache_line_words == 8'h02)
      || (cache_line_words == 8'h04) || (cache_line_words == 8'h08)
      || (cache_line_words == 8'h10) || (cache_line_words == 8'h20)
      || (cache_line_words == 8'h40) || (cache_line_words == 8'h80))
      else $error("cache line size holds an illegal value");

   cache_bad_zero_a: assert property (
      core_ce && cfg_write && cfg_dword == DW_MISC && cfg_byte_en[0]
      && cfg_wdata[7:0] == 8'h03 |=> cache_line_words == 8'h00)
      else $error("illegal cache line write not read as zero");

   class_code_read_a: assert property (
      core_ce && cfg_read && cfg_dword == DW_CLASS
      |=> cfg_rvalid && cfg_rdata == 32'h0C001000)
      else $error("class code read wrong");

   misc_const_read_a: assert property (
      core_ce && cfg_read && cfg_dword == DW_MISC
      |=> cfg_rdata[31:16] == 16'h0000 && cfg_rdata[15:8] == $past(bus_hold_clocks))
      else $error("header or self test byte not zero");

   base_low_zero_a: assert property (
      core_ce && cfg_read && cfg_dword == DW_BASE
      |=> cfg_rdata[11:0] == 12'h000 && cfg_rdata[31:12] == $past(op_base_page))
      else $error("base low bits not zero");

   base_write_take_a: assert property (
      core_ce && cfg_write && cfg_dword == DW_BASE && cfg_byte_en == 4'hF
      |=> op_base_page == $past(cfg_wdata[31:12]))
      else $error("base upper bits not written");

   irq_dword_read_a: assert property (
      core_ce && cfg_read && cfg_dword == DW_IRQ
      |=> cfg_rdata[15:8] == 8'h01 && cfg_rdata[7:0] == $past(irq_route_line))
      else $error("interrupt pin or line read wrong");

   ro_write_keep_a: assert property (
      core_ce && !ee_load && cfg_write && cfg_dword == DW_SUBS
      |=> $stable(st.subsys_vend) && $stable(st.subsys))
      else $error("read only subsystem field changed by write");

   ctrl_upper_zero_a: assert property (
      core_ce && cfg_read && cfg_dword == DW_CTRL
      |=> cfg_rdata == {31'h00000000, $past(swap_enable)})
      else $error("control reserved bits not zero");

   cap_header_read_a: assert property (
      core_ce && cfg_read && cfg_dword == DW_PCAP
      |=> cfg_rdata == 32'h00000001)
      else $error("capability header read wrong");

   swap_data_a: assert property (
      core_ce && quad_in_valid && swap_enable && !quad_in_exempt
      |=> quad_out_valid
          && quad_out == {$past(quad_in[7:0]), $past(quad_in[15:8]),
                          $past(quad_in[23:16]), $past(quad_in[31:24])})
      else $error("quadlet not byte reversed");

   ee_load_take_a: assert property (
      core_ce && ee_load |=> st.burst_need == $past(ee_burst_need)
                              && st.access_need == $past(ee_access_need))
      else $error("serial memory preset not loaded");

   // lane checks for the bus hold, irq line and swap fields and the enable, plus capability pointer, subsystem read and unswapped data path checks
   ce_freeze_a: assert property (
      !core_ce |=> $stable(st))
      else $error("state moved with enable low");

   hold_write_take_a: assert property (
      core_ce && cfg_write && cfg_dword == DW_MISC && cfg_byte_en[1]
      |=> bus_hold_clocks == $past(cfg_wdata[15:8]))
      else $error("bus hold timer not written");

   irq_line_take_a: assert property (
      core_ce && cfg_write && cfg_dword == DW_IRQ && cfg_byte_en[0]
      |=> irq_route_line == $past(cfg_wdata[7:0]))
      else $error("interrupt line not written");

   cap_ptr_read_a: assert property (
      core_ce && cfg_read && cfg_dword == DW_CAPP
      |=> cfg_rdata == 32'h00000060)
      else $error("capability pointer read wrong");

   swap_take_a: assert property (
      core_ce && cfg_write && cfg_dword == DW_CTRL && cfg_byte_en[0]
      |=> swap_enable == $past(cfg_wdata[0]))
      else $error("swap control bit not written");

   exempt_pass_a: assert property (
      core_ce && quad_in_valid && (!swap_enable || quad_in_exempt)
      |=> quad_out_valid && quad_out == $past(quad_in))
      else $error("unswapped quadlet altered");

   subsys_read_a: assert property (
      core_ce && cfg_read && cfg_dword == DW_SUBS
      |=> cfg_rdata == {$past(st.subsys), $past(st.subsys_vend)})
      else $error("subsystem codes read wrong");

endmodule

`default_nettype wire

// ---- pch_host_model.sv ----
// host bridge model issuing configuration reads and writes
`timescale 1ns/1ps
`default_nettype none

module pch_host_model (
   // clock
   input  wire logic        core_clk,
   // request side
   output var  logic        cfg_write,
   output var  logic        cfg_read,
   output var  logic [5:0]  cfg_dword,
   output var  logic [3:0]  cfg_byte_en,
   output var  logic [31:0] cfg_wdata,
   // answer side
   input  wire logic [31:0] cfg_rdata,
   input  wire logic        cfg_rvalid
);
   // ------------------------------------------------------------
   // idle lines at time zero
   // ------------------------------------------------------------
   initial begin
      cfg_write   = 1'b0;
      cfg_read    = 1'b0;
      cfg_dword   = 6'h00;
      cfg_byte_en = 4'h0;
      cfg_wdata   = 32'h00000000;
   end

   // one write; idle lines then show the inverse, never a stale copy
   task automatic wr(input logic [5:0] dw, input logic [3:0] be, input logic [31:0] d);
      @(posedge core_clk);
      cfg_write   <= 1'b1;
      cfg_dword   <= dw;
      cfg_byte_en <= be;
      cfg_wdata   <= d;
      @(posedge core_clk);
      cfg_write   <= 1'b0;
      cfg_dword   <= ~dw;
      cfg_byte_en <= ~be;
      cfg_wdata   <= ~d;
   endtask

   // one read; answer looked at once the taking edge has landed
   task automatic rd(input logic [5:0] dw, output logic [31:0] d, output logic ok);
      @(posedge core_clk);
      cfg_read  <= 1'b1;
      cfg_dword <= dw;
      @(posedge core_clk);
      cfg_read  <= 1'b0;
      cfg_dword <= ~dw;
      #1;
      ok = cfg_rvalid;
      d  = cfg_rdata;
   endtask
endmodule
`default_nettype wire

// ---- pch_pkg.sv ----
// shared constants and types for the configuration header register bank
package pch_pkg;

   // ---------------------------------------------------------------
   // configuration byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFF_CLASS_CODE   = 8'h09; // class code, bytes 9..B
   localparam logic [7:0] OFF_CACHE_LINE   = 8'h0C; // cache line size
   localparam logic [7:0] OFF_BUS_HOLD     = 8'h0D; // bus hold timer
   localparam logic [7:0] OFF_HEADER_TYPE  = 8'h0E; // header layout type
   localparam logic [7:0] OFF_SELF_TEST    = 8'h0F; // self test control
   localparam logic [7:0] OFF_OP_BASE      = 8'h10; // operation register base
   localparam logic [7:0] OFF_SUBSYS_VEND  = 8'h2C; // subsystem vendor code
   localparam logic [7:0] OFF_SUBSYS       = 8'h2E; // subsystem code
   localparam logic [7:0] OFF_CAP_PTR      = 8'h34; // capability list pointer
   localparam logic [7:0] OFF_IRQ_LINE     = 8'h3C; // interrupt routing line
   localparam logic [7:0] OFF_IRQ_PIN      = 8'h3D; // interrupt request pin
   localparam logic [7:0] OFF_BURST_NEED   = 8'h3E; // burst length need
   localparam logic [7:0] OFF_ACCESS_NEED  = 8'h3F; // access interval need
   localparam logic [7:0] OFF_HOST_CTRL    = 8'h40; // host ctrl pci control
   localparam logic [7:0] OFF_POWER_CAP    = 8'h60; // power cap header

   // ---------------------------------------------------------------
   // constant field values
   // ---------------------------------------------------------------
   localparam logic [7:0]  CLASS_PROG_IF   = 8'h10; // programming interface
   localparam logic [7:0]  CLASS_SUB       = 8'h00; // subclass
   localparam logic [7:0]  CLASS_BASE      = 8'h0C; // serial bus controller
   localparam logic [7:0]  HEADER_TYPE_VAL = 8'h00; // single function
   localparam logic [7:0]  SELF_TEST_VAL   = 8'h00; // no self test
   localparam logic [7:0]  CAP_PTR_VAL     = 8'h60; // first capability entry
   localparam logic [7:0]  IRQ_PIN_VAL     = 8'h01; // interrupt line a
   localparam logic [7:0]  CAPABILITY_IDENTIFIER_VAL      = 8'h01; // power management id
   localparam logic [7:0]  CAP_NEXT_VAL    = 8'h00; // end of list
   localparam logic [11:0] OP_BASE_LOW     = 12'h000; // hardwired low bits

   // ---------------------------------------------------------------
   // field layout and reset values
   // ---------------------------------------------------------------
   localparam int          OP_BASE_LSB     = 12;     // first writable bit
   localparam int          SWAP_BIT        = 0;      // swap control bit
   localparam logic [7:0]  CACHE_LINE_MIN  = 8'h02;  // smallest legal size
   localparam logic [7:0]  CACHE_LINE_MAX  = 8'h80;  // largest legal size
   localparam logic [7:0]  RST_CACHE_LINE  = 8'h00;
   localparam logic [7:0]  RST_BUS_HOLD    = 8'h00;
   localparam logic [19:0] RST_OP_BASE     = 20'h00000;
   localparam logic [7:0]  RST_IRQ_LINE    = 8'h00;
   localparam logic [7:0]  RST_BURST_NEED  = 8'h00;
   localparam logic [7:0]  RST_ACCESS_NEED = 8'h00;
   localparam logic        RST_SWAP        = 1'b0;
   localparam logic [15:0] RST_SUBSYS_VEND = 16'h5A5A; // arbitrary value
   localparam logic [15:0] RST_SUBSYS      = 16'hA5A5; // arbitrary value

   // ---------------------------------------------------------------
   // module state, one packed record
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [7:0]  cache_line;    // legalised cache line size
      logic [7:0]  bus_hold;      // bus hold timer
      logic [19:0] op_base;       // operation base, bits 31..12
      logic [15:0] subsys_vend;   // loaded subsystem vendor code
      logic [15:0] subsys;        // loaded subsystem code
      logic [7:0]  irq_line;      // interrupt routing line
      logic [7:0]  burst_need;    // loaded burst length need
      logic [7:0]  access_need;   // loaded access interval need
      logic        swap;          // global swap control
      logic [31:0] rdata;         // config read data
      logic        rvalid;        // config read answer
      logic [31:0] quad_out;      // data path quadlet out
      logic        quad_valid;    // data path valid out
   } pch_state_t;

endpackage

// ---- test_pch_config_regs.sv ----
// self-checking bench for the configuration header register bank
`timescale 1ns/1ps
`default_nettype none

module test_pch_config_regs;
   // ------------------------------------------------------------
   // design connections
   // ------------------------------------------------------------
   logic core_clk = 1'b0, rst_b = 1'b0, core_ce = 1'b1;   // clock, reset, enable
   logic cfg_write, cfg_read, cfg_rvalid;                 // request and answer strobes
   logic [5:0] cfg_dword;                                 // dword index
   logic [3:0] cfg_byte_en;                               // byte lanes
   logic [31:0] cfg_wdata, cfg_rdata;                     // data
   logic ee_load = 1'b0;                                  // preset strobe
   logic [15:0] ee_subsys_vend = 16'h0, ee_subsys = 16'h0; // preset codes
   logic [7:0] ee_burst_need = 8'h0, ee_access_need = 8'h0; // preset needs
   logic quad_in_valid = 1'b0, quad_in_exempt = 1'b0, quad_out_valid; // data path flags
   logic [31:0] quad_in = 32'h0, quad_out;                // data path quadlets
   logic [7:0] cache_line_words, bus_hold_clocks, irq_route_line; // settings
   logic [19:0] op_base_page;                             // base page
   logic swap_enable;                                     // swap setting
   // expected state kept by the bench
   logic [7:0] cl, hold, irq, burst, acc;
   logic [19:0] base;
   logic [15:0] sv, ss;
   logic swp;
   int miscompares = 0, checked = 0;
   logic [5:0] tbl [8] = '{6'h02, 6'h03, 6'h04, 6'h0B, 6'h0D, 6'h0F, 6'h10, 6'h18};

   pch_config_regs uut (.core_clk(core_clk), .rst_b(rst_b), .core_ce(core_ce),
      .cfg_write(cfg_write), .cfg_read(cfg_read), .cfg_dword(cfg_dword),
      .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
      .cfg_rvalid(cfg_rvalid), .ee_load(ee_load), .ee_subsys_vend(ee_subsys_vend),
      .ee_subsys(ee_subsys), .ee_burst_need(ee_burst_need), .ee_access_need(ee_access_need),
      .quad_in_valid(quad_in_valid), .quad_in_exempt(quad_in_exempt), .quad_in(quad_in),
      .quad_out(quad_out), .quad_out_valid(quad_out_valid),
      .cache_line_words(cache_line_words), .bus_hold_clocks(bus_hold_clocks),
      .op_base_page(op_base_page), .irq_route_line(irq_route_line),
      .swap_enable(swap_enable));

   pch_host_model host (.core_clk(core_clk), .cfg_write(cfg_write), .cfg_read(cfg_read),
      .cfg_dword(cfg_dword), .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata),
      .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid));

   // ------------------------------------------------------------
   // clock and watchdog
   // ------------------------------------------------------------
   always #2 core_clk = ~core_clk;  // 250 MHz

   // whole run is a few thousand cycles, so 25000 cycles means a hang
   initial begin
      #100000;
      miscompares++;
      $display("ERROR %0t watchdog expired", $time);
      tally_and_finish();
   end

   // ------------------------------------------------------------
   // expectation helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] exp_rd(input logic [5:0] dw);
      case (dw)
         6'h02: exp_rd = 32'h0C001000;
         6'h03: exp_rd = {16'h0000, hold, cl};
         6'h04: exp_rd = {base, 12'h000};
         6'h0B: exp_rd = {ss, sv};
         6'h0D: exp_rd = 32'h00000060;
         6'h0F: exp_rd = {acc, burst, 8'h01, irq};
         6'h10: exp_rd = {31'h0, swp};
         6'h18: exp_rd = 32'h00000001;
         default: exp_rd = 32'h00000000;
      endcase
   endfunction

   function automatic logic [31:0] rev32(input logic [31:0] d);
      rev32 = {d[7:0], d[15:8], d[23:16], d[31:24]};
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // settings outputs against the expected state
   task automatic outs;
      chk({cache_line_words, bus_hold_clocks, irq_route_line, 7'h0, swap_enable},
          {cl, hold, irq, 7'h0, swp});
      chk({12'h0, op_base_page}, {12'h0, base});
   endtask

   // write, then follow it in the expected state; read-only lanes stay put
   task automatic wrchk(input logic [5:0] dw, input logic [3:0] be, input logic [31:0] d);
      host.wr(dw, be, d);
      if (dw == 6'h03 && be[0]) cl = (d[7:0] inside {8'h02, 8'h04, 8'h08, 8'h10,
                                      8'h20, 8'h40, 8'h80}) ? d[7:0] : 8'h00;
      if (dw == 6'h03 && be[1]) hold = d[15:8];
      if (dw == 6'h04 && be[1]) base[3:0] = d[15:12];
      if (dw == 6'h04 && be[2]) base[11:4] = d[23:16];
      if (dw == 6'h04 && be[3]) base[19:12] = d[31:24];
      if (dw == 6'h0F && be[0]) irq = d[7:0];
      if (dw == 6'h10 && be[0]) swp = d[0];
      #1;
      outs();
   endtask

   task automatic rdchk(input logic [5:0] dw);
      logic [31:0] d;
      logic        ok;
      host.rd(dw, d, ok);
      chk({31'h0, ok}, 32'h1);
      chk(d, exp_rd(dw));
   endtask

   task automatic reset_all;
      @(posedge core_clk);
      rst_b <= 1'b0;
      repeat (5) @(posedge core_clk);
      {cl, hold, irq, burst, acc, base, swp} = '0;
      sv = pch_pkg::RST_SUBSYS_VEND;
      ss = pch_pkg::RST_SUBSYS;
      outs();
      rst_b <= 1'b1;
   endtask

   // preset load; lines go inverse afterwards
   task automatic preset;
      @(posedge core_clk);
      ee_load <= 1'b1;
      {ee_subsys_vend, ee_subsys} <= $urandom;
      {ee_burst_need, ee_access_need} <= 16'($urandom);
      @(posedge core_clk);
      ee_load <= 1'b0;
      {sv, ss, burst, acc} = {ee_subsys_vend, ee_subsys, ee_burst_need, ee_access_need};
      {ee_subsys_vend, ee_subsys, ee_burst_need, ee_access_need} <= ~{sv, ss, burst, acc};
   endtask

   task automatic quad(input logic [31:0] d, input logic ex);
      @(posedge core_clk);
      quad_in_valid  <= 1'b1;
      quad_in_exempt <= ex;
      quad_in        <= d;
      @(posedge core_clk);
      quad_in_valid <= 1'b0;
      quad_in       <= ~d;
      #1;
      chk({31'h0, quad_out_valid}, 32'h1);
      chk(quad_out, (swp && !ex) ? rev32(d) : d);
   endtask

   task automatic tally_and_finish;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      logic [5:0] dw;
      void'($urandom(4263));
      reset_all();
      for (int i = 0; i < 64; i++) rdchk(6'(i));
      // firmware maps the operation registers first
      wrchk(6'h04, 4'hF, 32'hFEDCBFFF);
      wrchk(6'h04, 4'h2, 32'h00005A00);
      rdchk(6'h04);
      // every cache line value, upper lanes masked off
      for (int v = 0; v < 256; v++) begin
         wrchk(6'h03, 4'h1, {24'($urandom), 8'(v)});
         rdchk(6'h03);
      end
      // presets, then attempts to overwrite them
      preset();
      wrchk(6'h0B, 4'hF, ~{ss, sv});
      wrchk(6'h0F, 4'hF, $urandom);
      rdchk(6'h0B);
      rdchk(6'h0F);
      // enable low: a write and a load at once are both held off
      core_ce <= 1'b0;
      ee_load <= 1'b1;
      host.wr(6'h03, 4'h3, ~{16'h0, hold, cl});
      core_ce <= 1'b1;
      ee_load <= 1'b0;
      #1;
      outs();
      rdchk(6'h0B);
      wrchk(6'h10, 4'hF, 32'hFFFFFFFF);
      rdchk(6'h10);
      quad($urandom, 1'b0);
      quad($urandom, 1'b1);
      // random traffic, mostly on mapped dwords
      repeat (300) begin
         dw = ($urandom_range(0, 3) == 0) ? 6'($urandom) : tbl[$urandom_range(0, 7)];
         wrchk(dw, 4'($urandom), $urandom);
         rdchk(dw);
         if (dw[0]) quad($urandom, 1'($urandom));
         if (dw == 6'h0B) preset();
      end
      // second reset in mid-run
      reset_all();
      for (int i = 0; i < 64; i++) rdchk(6'(i));
      tally_and_finish();
   end
endmodule
`default_nettype wire
